// ### itsup_params.svh
/*
 Constants for the interrupt task supervisor: register byte offsets, field positions,
 reset values and timing counts. Assumes inclusion from the supervisor sources only.
*/
`ifndef ITSUP_PARAMS_SVH
`define ITSUP_PARAMS_SVH
`define ITSUP_OFF_PEAK_TIME 12'h000
`define ITSUP_OFF_PEAK_TASK 12'h004
`define ITSUP_OFF_FAULT_TASK 12'h008
`define ITSUP_OFF_STOP_TASK 12'h00C
`define ITSUP_OFF_FLAGS 12'h010
`define ITSUP_OFF_SETUP 12'h014
`define ITSUP_BIT_FIRST_SEEN 15
`define ITSUP_BIT_FAULT_KIND 15
`define ITSUP_BIT_DETECT_OFF 14
`define ITSUP_BIT_TASK_FAULT 0
`define ITSUP_BIT_UNIT_FAULT 1
`define ITSUP_BIT_REFRESH_STOP 2
`define ITSUP_INT_TASK_BASE 16'h8000
`define ITSUP_SETUP_RESET 16'h0000
`define ITSUP_TENTH_MS_NS 100000
`define ITSUP_LIMIT_MS 10
`define ITSUP_CLK_NS 4
`define ITSUP_TICK_CYCLES (`ITSUP_TENTH_MS_NS / `ITSUP_CLK_NS)
`define ITSUP_LIMIT_TICKS (`ITSUP_LIMIT_MS * 10)
`endif

// ### itsup_pkg.sv
/*
 Types shared by the interrupt task supervisor files.
 Assumes the params header is compiled alongside.
*/
package itsup_pkg;
   typedef enum logic [2:0] {
      ITSUP_IDLE = 3'b001,
      ITSUP_RUN = 3'b010,
      ITSUP_OVER = 3'b100
   } itsup_state_t;
   typedef enum logic [1:0] {
      ITSUP_K_REFRESH = 2'h0,
      ITSUP_K_FAST = 2'h1,
      ITSUP_K_READ = 2'h2,
      ITSUP_K_WRITE = 2'h3
   } itsup_kind_t;
endpackage

// ### itsup_timer.sv
/*
 Service timer: counts elapsed time of one interrupt task in tenth-millisecond ticks.
 Assumes start and stop pulses from the task engine, one clock domain.
*/
`timescale 1ns/1ps
`include "itsup_params.svh"
module itsup_timer #(
   parameter int TICK_CYCLES = `ITSUP_TICK_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic clear,
   input wire logic running,
   output logic [15:0] ticks
);
   logic [31:0] cycCount_r;

   always_ff @(posedge sys_clk) begin
      if (!rst_b || clear || !running) begin
         cycCount_r <= 32'h0;
         if (!rst_b || clear) begin
            ticks <= 16'h0;
         end
      end else if (cycCount_r == 32'(TICK_CYCLES - 1)) begin
         cycCount_r <= 32'h0;
         // Saturate so a runaway task cannot wrap back to a small time.
         if (ticks != 16'hFFFF) begin
            ticks <= ticks + 16'h1;
         end
      end else begin
         cycCount_r <= cycCount_r + 32'h1;
      end
   end
endmodule // itsup_timer

// ### interrupt_task_supervisor.sv
/*
 Interrupt task supervisor top: peak service time tracking, task fault capture,
 duplicate refresh conflict detection and stop task capture, with an APB register slave.
 Assumes task engine and refresh machinery strobes are synchronous to sys_clk.
*/
// Implementation choices: the APB interface to the registers and the address map.
// What this block does
// - Keep longest interrupt service time in 0.1 ms units, cleared at start.
// - Peak task word holds 8000 to 80FF hex for longest task.
// - Set first-interrupt-seen bit on first interrupt after start.
// - Later tasks: longest task number in low byte, cleared at start.
// - Task fault flag rises only while fault detection is enabled.
// - Over 10 ms during refresh: kind bit clear, task number stored.
// - Duplicate refresh: kind bit set, unit number 0 to 95 stored.
// - Interrupt unit instruction hitting a busy same-kind or end refresh unit conflicts.
// - Program error stop stores active task: 80xx interrupt, 00xx cyclic.
// - Over 10 ms during refresh: set unit fault flag, stop unit refresh.
// - Conflicting instruction skipped, no instruction error, cyclic refresh continues.
// - Setup bit 14: 0 enables fault detection, 1 disables; default 0.
`timescale 1ns/1ps
`include "itsup_params.svh"
module interrupt_task_supervisor
   import itsup_pkg::*;
#(
   parameter int TICK_CYCLES = `ITSUP_TICK_CYCLES,
   parameter int LIMIT_TICKS = `ITSUP_LIMIT_TICKS,
   parameter int MAX_UNIT = 95
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic opStart,
   input wire logic intStart,
   input wire logic intEnd,
   input wire logic [7:0] intTask,
   input wire logic unitRefreshActive,
   input wire logic instrValid,
   input wire logic [1:0] instrKind,
   input wire logic [6:0] instrUnit,
   input wire logic [3:0] cyclicBusyKinds,
   input wire logic [6:0] cyclicBusyUnit,
   input wire logic endRefreshBusy,
   input wire logic [6:0] endRefreshUnit,
   input wire logic progErrorStop,
   input wire logic stopIsInterrupt,
   input wire logic [7:0] stopTask,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic instrSkip,
   output logic unitRefreshStop,
   output logic specialUnitFault,
   output logic taskFault
);
   itsup_state_t state_r;
   logic [15:0] ticks;
   logic [15:0] peakTime_r;
   logic [15:0] peakTask_r;
   logic [15:0] faultTask_r;
   logic [15:0] stopTaskWord_r;
   logic [15:0] setup_r;
   logic [7:0] curTask_r;

   logic timerClear;
   logic timerRun;
   logic detectEn;
   logic overLimit;
   logic cyclicHit;
   logic endHit;
   logic conflict;
   logic newPeak;

   logic apbWrite;
   logic setupPhase;
   logic [31:0] readWord_nxt;
   logic readErr_nxt;

   function automatic logic [15:0] intCode(input logic [7:0] num);
      intCode = `ITSUP_INT_TASK_BASE | {8'h00, num};
   endfunction

   // Unit numbers above the last expansion unit never match.
   function automatic logic unitMatch(input logic [6:0] a, input logic [6:0] b);
      unitMatch = (a == b) && (a <= 7'(MAX_UNIT));
   endfunction

   // Every register is a 16-bit word; the upper half of the bus always reads as zero.
   function automatic logic [31:0] widen(input logic [15:0] w);
      widen = {16'h0000, w};
   endfunction

   function automatic logic writable(input logic [11:0] a);
      writable = (a == `ITSUP_OFF_SETUP);
   endfunction

   // Fault word: kind bit clear for an overlong task, set for a duplicate refresh.
   function automatic logic [15:0] faultCode(input logic kind, input logic [11:0] num);
      faultCode = {kind, 3'b000, num};
   endfunction

   // Cyclic tasks only span 0 to 31, so the upper task bits are dropped for them.
   function automatic logic [15:0] stopCode(input logic isInt, input logic [7:0] num);
      stopCode = isInt ? intCode(num) : {11'h000, num[4:0]};
   endfunction

   // The timer restarts on every task start, so each task is timed on its own.
   itsup_timer #(
      .TICK_CYCLES(TICK_CYCLES)
   ) u_timer (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .clear(timerClear),
      .running(timerRun),
      .ticks(ticks)
   );

   assign timerClear = intStart || opStart;
   assign timerRun = (state_r != ITSUP_IDLE);
   // A set setup bit turns detection off, so the reset default leaves it on.
   assign detectEn = !setup_r[`ITSUP_BIT_DETECT_OFF];
   // Checked while the task still runs, so unit refresh stops before the task ends.
   assign overLimit = (state_r == ITSUP_RUN) && unitRefreshActive
      && (ticks >= 16'(LIMIT_TICKS));
   // A conflict needs a busy cyclic instruction of the same kind, or end refresh.
   assign cyclicHit = cyclicBusyKinds[instrKind] && unitMatch(instrUnit, cyclicBusyUnit);
   assign endHit = endRefreshBusy && unitMatch(instrUnit, endRefreshUnit);
   assign conflict = instrValid && (state_r != ITSUP_IDLE)
      && (cyclicHit || endHit);
   assign apbWrite = psel && penable && pwrite;
   assign setupPhase = psel && !penable;
   assign newPeak = intEnd && (state_r != ITSUP_IDLE)
      && (!peakTask_r[`ITSUP_BIT_FIRST_SEEN] || (ticks > peakTime_r));

   always_ff @(posedge sys_clk) begin
      if (!rst_b || opStart) begin
         state_r <= ITSUP_IDLE;
      end else begin
         case (state_r)
            ITSUP_IDLE: begin
               if (intStart) begin
                  state_r <= ITSUP_RUN;
               end
            end
            ITSUP_RUN: begin
               if (intEnd) begin
                  state_r <= ITSUP_IDLE;
               end else if (overLimit) begin
                  state_r <= ITSUP_OVER;
               end
            end
            // An overlong task parks here so its fault fires only once.
            ITSUP_OVER: begin
               if (intEnd) begin
                  state_r <= ITSUP_IDLE;
               end
            end
            default: begin
               state_r <= ITSUP_IDLE;
            end
         endcase
      end
   end

   // The task number is latched only on a start taken from idle, with the state change.
   always_ff @(posedge sys_clk) begin
      if (!rst_b || opStart) begin
         curTask_r <= 8'h00;
      end else if ((state_r == ITSUP_IDLE) && intStart) begin
         curTask_r <= intTask;
      end
   end

   // Peak time compares on the end pulse, so the final partial tick is not counted as elapsed.
   always_ff @(posedge sys_clk) begin
      if (!rst_b || opStart) begin
         peakTime_r <= 16'h0000;
      end else if (newPeak) begin
         peakTime_r <= ticks;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b || opStart) begin
         peakTask_r <= 16'h0000;
      end else if (newPeak) begin
         peakTask_r <= intCode(curTask_r);
      end
   end

   // Fault state is sticky until the next start so software can read it later.
   // Over limit takes the fault word when both faults strike in one cycle.
   always_ff @(posedge sys_clk) begin
      if (!rst_b || opStart) begin
         taskFault <= 1'b0;
         faultTask_r <= 16'h0000;
      end else if (overLimit && detectEn) begin
         taskFault <= 1'b1;
         faultTask_r <= faultCode(1'b0, {4'h0, curTask_r});
      end else if (conflict && detectEn) begin
         taskFault <= 1'b1;
         faultTask_r <= faultCode(1'b1, {5'h00, instrUnit});
      end
   end

   // The unit side reacts to an overlong task whether or not detection is enabled.
   always_ff @(posedge sys_clk) begin
      if (!rst_b || opStart) begin
         specialUnitFault <= 1'b0;
         unitRefreshStop <= 1'b0;
      end else if (overLimit) begin
         specialUnitFault <= 1'b1;
         unitRefreshStop <= 1'b1;
      end
   end

   // The skip strobe never raises an instruction error; cyclic refresh is untouched.
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         instrSkip <= 1'b0;
      end else begin
         instrSkip <= conflict;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b || opStart) begin
         stopTaskWord_r <= 16'h0000;
      end else if (progErrorStop) begin
         stopTaskWord_r <= stopCode(stopIsInterrupt, stopTask);
      end
   end

   // Setup survives a start of operation; only reset restores the default.
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         setup_r <= `ITSUP_SETUP_RESET;
      end else if (apbWrite && writable(paddr)) begin
         setup_r <= pwdata[15:0];
      end
   end

   // Reads are fetched in the setup phase so the access phase answers in one cycle.
   always_comb begin
      readWord_nxt = 32'h00000000;
      readErr_nxt = 1'b0;
      if (paddr == `ITSUP_OFF_PEAK_TIME) begin
         readWord_nxt = widen(peakTime_r);
      end else if (paddr == `ITSUP_OFF_PEAK_TASK) begin
         readWord_nxt = widen(peakTask_r);
      end else if (paddr == `ITSUP_OFF_FAULT_TASK) begin
         readWord_nxt = widen(faultTask_r);
      end else if (paddr == `ITSUP_OFF_STOP_TASK) begin
         readWord_nxt = widen(stopTaskWord_r);
      end else if (paddr == `ITSUP_OFF_FLAGS) begin
         readWord_nxt = {29'h0, unitRefreshStop, specialUnitFault, taskFault};
      end else if (paddr == `ITSUP_OFF_SETUP) begin
         readWord_nxt = widen(setup_r);
      end else begin
         readErr_nxt = 1'b1;
      end
      // Writes to the read-only words are refused rather than silently dropped.
      if (pwrite && !writable(paddr)) begin
         readErr_nxt = 1'b1;
      end
   end

   // Zero wait states: the answer stands for exactly the access cycle.
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         pready <= 1'b0;
      end else begin
         pready <= setupPhase;
      end
   end

   // Read data only moves on a setup cycle, so an idle bus keeps the last answer.
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         prdata <= 32'h00000000;
      end else if (setupPhase) begin
         prdata <= readWord_nxt;
      end
   end

   // The error flag is a one-cycle answer like ready, never a sticky state.
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= setupPhase && readErr_nxt;
      end
   end
endmodule // interrupt_task_supervisor

// ### itsup_props.sv
/*
 Port checker for the interrupt task supervisor.
 Assumes one clock and the synchronous active-low reset.
*/
`timescale 1ns/1ps
module itsup_props #(
   parameter int TICK_CYCLES = 4,
   parameter int LIMIT_TICKS = 3
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic opStart,
   input wire logic intStart,
   input wire logic intEnd,
   input wire logic unitRefreshActive,
   input wire logic instrValid,
   input wire logic [1:0] instrKind,
   input wire logic [6:0] instrUnit,
   input wire logic [3:0] cyclicBusyKinds,
   input wire logic [6:0] cyclicBusyUnit,
   input wire logic endRefreshBusy,
   input wire logic [6:0] endRefreshUnit,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic instrSkip,
   input wire logic unitRefreshStop,
   input wire logic specialUnitFault,
   input wire logic taskFault
);
   logic run_r;
   logic detOff_r;
   logic [15:0] runCnt_r;
   logic hit;
   assign hit = instrValid && run_r && instrUnit <= 7'h5F
      && (cyclicBusyKinds[instrKind] && cyclicBusyUnit == instrUnit
      || endRefreshBusy && endRefreshUnit == instrUnit);
   always_ff @(posedge sys_clk) begin
      run_r <= rst_b && (intStart || (run_r && !intEnd));
      runCnt_r <= (!rst_b || intStart) ? 16'h0000 : runCnt_r + 16'(run_r);
   end
   // Setup survives a start of operation, so only reset clears this copy.
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         detOff_r <= 1'h0;
      end else if (psel && penable && pready && pwrite && paddr == 12'h014) begin
         detOff_r <= pwdata[14];
      end
   end
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_b);
   skip_on_hit_a: assert property (hit |=> instrSkip)
      else $error("conflicting instruction not skipped");
   no_false_skip_a: assert property (!hit |=> !instrSkip)
      else $error("skip without conflict");
   start_clear_a: assert property (opStart |=> !taskFault && !specialUnitFault)
      else $error("start of operation left a fault set");
   fault_hold_a: assert property (taskFault && !opStart |=> taskFault)
      else $error("task fault dropped early");
   stop_hold_a: assert property (unitRefreshStop && !opStart |=> unitRefreshStop)
      else $error("unit refresh resumed");
   unit_fault_pair_a: assert property (specialUnitFault |-> unitRefreshStop)
      else $error("unit fault without refresh stop");
   detect_gate_a: assert property ($rose(taskFault) |-> !detOff_r)
      else $error("task fault while detection off");
   over_limit_a: assert property (run_r && unitRefreshActive
      && runCnt_r > TICK_CYCLES * (LIMIT_TICKS + 1) + 2 |-> specialUnitFault)
      else $error("overlong task not flagged");
   refresh_clear_a: assert property (opStart |=> !unitRefreshStop)
      else $error("start of operation left refresh stopped");
   ready_zero_wait_a: assert property (psel && !penable |=> pready)
      else $error("access phase not answered");
endmodule // itsup_props
bind interrupt_task_supervisor itsup_props #(.TICK_CYCLES(TICK_CYCLES),
   .LIMIT_TICKS(LIMIT_TICKS)) chk (.*);

// ### itsup_unit_model.sv
/*
 Expansion unit refresh side: turns bench commands into busy levels one cycle later.
 Assumes the bench sets cmdMode and cmdUnit just after a clock edge.
*/
`timescale 1ns/1ps
module itsup_unit_model (
   input wire logic sys_clk,
   input wire logic [5:0] cmdMode,
   input wire logic [6:0] cmdUnit,
   output logic unitRefreshActive = 1'h0,
   output logic [3:0] cyclicBusyKinds = 4'h0,
   output logic [6:0] cyclicBusyUnit = 7'h00,
   output logic endRefreshBusy = 1'h0,
   output logic [6:0] endRefreshUnit = 7'h00
);
   // An idle unit number carries nothing, so it wanders instead of holding.
   always @(posedge sys_clk) begin
      {endRefreshBusy, cyclicBusyKinds, unitRefreshActive} <= cmdMode;
      cyclicBusyUnit <= |cmdMode[4:1] ? cmdUnit : ~cyclicBusyUnit;
      endRefreshUnit <= cmdMode[5] ? cmdUnit : ~endRefreshUnit;
   end
endmodule // itsup_unit_model

// ### tb_interrupt_task_supervisor.sv
/*
 Self-checking bench for the interrupt task supervisor.
 Assumes the unit model and the checker are compiled alongside.
*/
`timescale 1ns/1ps
module tb_interrupt_task_supervisor;
   logic sys_clk = 1'h0, rst_b = 1'h0, opStart = 1'h0, intStart = 1'h0, intEnd = 1'h0;
   logic instrValid = 1'h0, progErrorStop = 1'h0, stopIsInterrupt = 1'h0;
   logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr, slvErr;
   logic instrSkip, unitRefreshStop, specialUnitFault, taskFault;
   logic unitRefreshActive, endRefreshBusy;
   logic [1:0] instrKind = 2'h0;
   logic [3:0] cyclicBusyKinds;
   logic [5:0] cmdMode = 6'h00;
   logic [6:0] instrUnit = 7'h00, cmdUnit = 7'h00, cyclicBusyUnit, endRefreshUnit;
   logic [7:0] intTask = 8'h00, stopTask = 8'h00;
   logic [8:0] stopCase [3] = '{9'h100, 9'h1FF, 9'h01F};
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   int errors = 0, n_compared = 0;
   always #2 sys_clk = ~sys_clk;
   interrupt_task_supervisor #(.TICK_CYCLES(4), .LIMIT_TICKS(3)) dut (.*);
   itsup_unit_model partner (.*);
   task automatic summarize;
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge sys_clk);
      {psel, pwrite, paddr, pwdata} <= {1'h1, wr, a, d};
      @(posedge sys_clk);
      penable <= 1'h1;
      do @(posedge sys_clk); while (pready !== 1'h1 && ++n < 9);
      if (pready !== 1'h1) errors++;
      {rd, slvErr} = {prdata, pslverr};
      {psel, penable} <= 2'h0;
   endtask
   task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
      apb(1'h0, a, 32'h0);
      check({slvErr, rd}, {1'h0, e});
   endtask
   task automatic strobe(input logic [3:0] s);
      @(posedge sys_clk);
      {opStart, intStart, intEnd, progErrorStop} <= s;
      @(posedge sys_clk);
      {opStart, intStart, intEnd, progErrorStop} <= 4'h0;
   endtask
   task automatic runInt(input logic [7:0] t, input int cyc);
      intTask <= t;
      strobe(4'h4);
      repeat (cyc) @(posedge sys_clk);
      strobe(4'h2);
   endtask
   task automatic issue(input logic [1:0] k, input logic [6:0] u, input logic e);
      @(posedge sys_clk);
      {instrValid, instrKind, instrUnit} <= {1'h1, k, u};
      @(posedge sys_clk);
      instrValid <= 1'h0;
      @(posedge sys_clk);
      check(instrSkip, e);
   endtask
   task automatic prep(input logic d);
      strobe(4'h8);
      apb(1'h1, 12'h014, {d, 14'h0000});
      rdchk(12'h014, {d, 14'h0000});
   endtask
   task automatic tReset;
      for (int k = 0; k < 6; k++) rdchk(12'(4 * k), 32'h0);
      apb(1'h0, 12'h018, 32'h0);
      check(slvErr, 1'h1);
      apb(1'h1, 12'h000, 32'h5);
      check(slvErr, 1'h1);
      rdchk(12'h000, 32'h0);
   endtask
   task automatic tPeak;
      strobe(4'h8);
      runInt(8'h05, 8);
      rdchk(12'h004, 32'h8005);
      runInt(8'hA3, 40);
      runInt(8'h11, 4);
      rdchk(12'h004, 32'h80A3);
      apb(1'h0, 12'h000, 32'h0);
      check(rd >= 9 && rd <= 11, 1'h1);
   endtask
   task automatic tOver(input logic d);
      prep(d);
      cmdMode <= 6'h01;
      runInt(8'h2C, 30);
      cmdMode <= 6'h00;
      check({unitRefreshStop, specialUnitFault, taskFault}, {2'h3, !d});
      rdchk(12'h010, {2'h3, !d});
      if (!d) rdchk(12'h008, 32'h002C);
      strobe(4'h8);
      @(posedge sys_clk);
      check({unitRefreshStop, specialUnitFault, taskFault}, 3'h0);
   endtask
   task automatic tConflict(input logic d);
      prep(d);
      {cmdMode, cmdUnit} <= {6'h20, 7'h5F};
      intTask <= 8'h09;
      strobe(4'h4);
      issue(2'h2, 7'h5F, 1'h1);
      check(taskFault, !d);
      if (!d) rdchk(12'h008, 32'h805F);
      // Cyclic refresh deliberately left on for units the task also serves.
      for (int k = 0; k < 4; k++) begin
         {cmdMode, cmdUnit} <= {6'(2 << k), 7'h20 + 7'(k)};
         issue(2'(k), 7'h20 + 7'(k), 1'h1);
         issue(2'(k + 1), 7'h20 + 7'(k), 1'h0);
      end
      strobe(4'h2);
      cmdMode <= 6'h00;
      check(unitRefreshStop, 1'h0);
   endtask
   task automatic tStop;
      for (int k = 0; k < 3; k++) begin
         {stopIsInterrupt, stopTask} <= stopCase[k];
         strobe(4'h1);
         rdchk(12'h00C, {stopCase[k][8], 7'h00, stopCase[k][7:0]});
      end
   endtask
   initial begin
      #100000;
      errors++;
      summarize();
   end
   initial begin
      repeat (4) @(posedge sys_clk);
      rst_b <= 1'h1;
      tReset();
      tPeak();
      tOver(1'h0);
      tOver(1'h1);
      tConflict(1'h0);
      tConflict(1'h1);
      tStop();
      summarize();
   end
endmodule // tb_interrupt_task_supervisor
